/* rtl/ldr_regs.svh */
// register offsets, field positions and reset values of the lighting director
`ifndef LDR_REGS_SVH
`define LDR_REGS_SVH

`define LDR_ADDR_RAW_X_HIGH     8'h08
`define LDR_ADDR_RAW_X_LOW      8'h09
`define LDR_ADDR_RAW_Y_HIGH     8'h0a
`define LDR_ADDR_RAW_Y_LOW      8'h0b
`define LDR_ADDR_RAW_Z_HIGH     8'h0c
`define LDR_ADDR_RAW_Z_LOW      8'h0d
`define LDR_ADDR_SETUP          8'h60
`define LDR_ADDR_HANDSHAKE      8'h61
`define LDR_ADDR_RES1_HIGH      8'h62
`define LDR_ADDR_RES1_LOW       8'h63
`define LDR_ADDR_RES2_HIGH      8'h64
`define LDR_ADDR_RES2_LOW       8'h65
`define LDR_ADDR_RES3_HIGH      8'h66
`define LDR_ADDR_RES3_LOW       8'h67
`define LDR_ADDR_LUX_HIGH       8'h70
`define LDR_ADDR_LUX_LOW        8'h71
`define LDR_ADDR_CCT_HIGH       8'h72
`define LDR_ADDR_CCT_LOW        8'h73

`define LDR_START_BIT           0
`define LDR_MODE_MSB            7
`define LDR_MODE_LSB            4
`define LDR_HIGH_MSB            15
`define LDR_HIGH_LSB            8
`define LDR_LOW_MSB             7
`define LDR_LOW_LSB             0

`define LDR_MODE_DAY            4'h0
`define LDR_MODE_DAY_TUNE       4'h1
`define LDR_MODE_DAY_TUNE_TWO   4'h2

`define LDR_RESET_BYTE          8'h00
`define LDR_RESET_WORD          16'h0000
`define LDR_RESET_MODE          4'h0
`define LDR_RESET_START         1'b0
`define LDR_UNMAPPED_READ       8'h00

`endif

/* rtl/ldr_pkg.sv */
// types shared by the lighting director register bank
package ldr_pkg;

	typedef logic [3:0] ldr_mode_t;

	typedef logic [15:0] ldr_word_t;

	typedef enum {
		ldr_st_idle,
		ldr_st_wait,
		ldr_st_load,
		ldr_st_clear
	} ldr_state_t;

endpackage

/* rtl/ldr_pair_reg.sv */
// one result byte pair, loaded as a whole word
`timescale 1ns/1ns
`default_nettype none
`include "ldr_regs.svh"

module ldr_pair_reg #(
	parameter int W = 16
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	output logic      [W-1:0] o_value
);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_value <= '0;
		end else if (i_load) begin
			o_value <= i_value;
		end
	end

endmodule // ldr_pair_reg

`default_nettype wire

/* rtl/ldr_result_regs.sv */
// lighting director register bank: handshake, results, targets, raw values
// Operation
// - device clears start on results, reset
// - colour tuning channel 1 sixteen bit, high first
// - daylighting channel 1 sixteen bit percentage
// - channel 1 dimming, mode 2 brightness only
// - channels 2 and 3 sixteen bit percentages
// - channel 2 zero in modes 0 and 3..15, tuned in modes 1 and 2
// - channel 3 zero in modes 0 and 3..15, tuned in modes 1 and 2
// - lux target word, high byte lower address
// - colour temperature target reads back unchanged
// - targets and results reset to zero
// - raw x y z read only byte pairs
// - channel mode in setup bits 7:4
`timescale 1ns/1ns
`default_nettype none
`include "ldr_regs.svh"

module ldr_result_regs (
	input  wire logic              i_ref_clk,
	input  wire logic              i_nrst,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	input  wire logic              i_raw_valid,
	input  wire ldr_pkg::ldr_word_t i_raw_x,
	input  wire ldr_pkg::ldr_word_t i_raw_y,
	input  wire ldr_pkg::ldr_word_t i_raw_z,
	input  wire logic              i_result_valid,
	input  wire ldr_pkg::ldr_word_t i_ch1_value,
	input  wire ldr_pkg::ldr_word_t i_ch2_value,
	input  wire ldr_pkg::ldr_word_t i_ch3_value,
	output logic                   o_conv_start,
	output ldr_pkg::ldr_mode_t     o_channel_mode,
	output ldr_pkg::ldr_word_t     o_lux_target,
	output ldr_pkg::ldr_word_t     o_cct_target
);
	import ldr_pkg::*;

	ldr_state_t state_reg;
	ldr_state_t state_next;
	logic       start_reg;
	logic       start_next;
	ldr_mode_t  mode_reg;
	ldr_word_t  lux_reg;
	ldr_word_t  cct_reg;
	ldr_word_t  raw_x_reg;
	ldr_word_t  raw_y_reg;
	ldr_word_t  raw_z_reg;
	ldr_word_t  cap1_reg;
	ldr_word_t  cap2_reg;
	ldr_word_t  cap3_reg;
	ldr_word_t  ch1_q;
	ldr_word_t  ch2_q;
	ldr_word_t  ch3_q;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// address decode
	wire hit_raw_x_h  = (i_addr == `LDR_ADDR_RAW_X_HIGH);
	wire hit_raw_x_l  = (i_addr == `LDR_ADDR_RAW_X_LOW);
	wire hit_raw_y_h  = (i_addr == `LDR_ADDR_RAW_Y_HIGH);
	wire hit_raw_y_l  = (i_addr == `LDR_ADDR_RAW_Y_LOW);
	wire hit_raw_z_h  = (i_addr == `LDR_ADDR_RAW_Z_HIGH);
	wire hit_raw_z_l  = (i_addr == `LDR_ADDR_RAW_Z_LOW);
	wire hit_setup    = (i_addr == `LDR_ADDR_SETUP);
	wire hit_hand     = (i_addr == `LDR_ADDR_HANDSHAKE);
	wire hit_res1_h   = (i_addr == `LDR_ADDR_RES1_HIGH);
	wire hit_res1_l   = (i_addr == `LDR_ADDR_RES1_LOW);
	wire hit_res2_h   = (i_addr == `LDR_ADDR_RES2_HIGH);
	wire hit_res2_l   = (i_addr == `LDR_ADDR_RES2_LOW);
	wire hit_res3_h   = (i_addr == `LDR_ADDR_RES3_HIGH);
	wire hit_res3_l   = (i_addr == `LDR_ADDR_RES3_LOW);
	wire hit_lux_h    = (i_addr == `LDR_ADDR_LUX_HIGH);
	wire hit_lux_l    = (i_addr == `LDR_ADDR_LUX_LOW);
	wire hit_cct_h    = (i_addr == `LDR_ADDR_CCT_HIGH);
	wire hit_cct_l    = (i_addr == `LDR_ADDR_CCT_LOW);

	wire wr_setup     = i_wr & hit_setup;
	wire wr_hand      = i_wr & hit_hand;
	wire wr_lux_h     = i_wr & hit_lux_h;
	wire wr_lux_l     = i_wr & hit_lux_l;
	wire wr_cct_h     = i_wr & hit_cct_h;
	wire wr_cct_l     = i_wr & hit_cct_l;

	// reserved modes 3..15 leave channels 2 and 3 at zero, like mode 0
	wire mode_tuning  = (mode_reg == `LDR_MODE_DAY_TUNE) ||
	                    (mode_reg == `LDR_MODE_DAY_TUNE_TWO);

	wire       load_pairs = (state_reg == ldr_st_load);
	ldr_word_t ch2_load_val;
	ldr_word_t ch3_load_val;
	assign ch2_load_val = mode_tuning ? cap2_reg : `LDR_RESET_WORD;
	assign ch3_load_val = mode_tuning ? cap3_reg : `LDR_RESET_WORD;

	// channel 1 holds dimming in modes 0/1, brightness in mode 2
	ldr_pair_reg #(.W(16)) u_res1 (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_load    (load_pairs),
		.i_value   (cap1_reg),
		.o_value   (ch1_q)
	);

	ldr_pair_reg #(.W(16)) u_res2 (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_load    (load_pairs),
		.i_value   (ch2_load_val),
		.o_value   (ch2_q)
	);

	ldr_pair_reg #(.W(16)) u_res3 (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_load    (load_pairs),
		.i_value   (ch3_load_val),
		.o_value   (ch3_q)
	);

	// handshake: a host write in the clearing cycle wins, so a new
	// request made right at the hand-back is not lost
	assign start_next = wr_hand ? i_wdata[`LDR_START_BIT] :
	                    (state_reg == ldr_st_clear) ? `LDR_RESET_START : start_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ldr_st_idle: begin
				if (start_reg) begin
					state_next = ldr_st_wait;
				end
			end
			ldr_st_wait: begin
				if (!start_reg) begin
					state_next = ldr_st_idle;
				end else if (i_result_valid) begin
					state_next = ldr_st_load;
				end
			end
			ldr_st_load: begin
				state_next = ldr_st_clear;
			end
			ldr_st_clear: begin
				state_next = ldr_st_idle;
			end
			default: begin
				state_next = ldr_st_idle;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ldr_st_idle;
			start_reg <= `LDR_RESET_START;
		end else begin
			state_reg <= state_next;
			start_reg <= start_next;
		end
	end

	// results captured only while a conversion is requested
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cap1_reg <= `LDR_RESET_WORD;
			cap2_reg <= `LDR_RESET_WORD;
			cap3_reg <= `LDR_RESET_WORD;
		end else if (state_reg == ldr_st_wait && start_reg && i_result_valid) begin
			cap1_reg <= i_ch1_value;
			cap2_reg <= i_ch2_value;
			cap3_reg <= i_ch3_value;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_reg <= `LDR_RESET_MODE;
		end else if (wr_setup) begin
			mode_reg <= i_wdata[`LDR_MODE_MSB:`LDR_MODE_LSB];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lux_reg <= `LDR_RESET_WORD;
			cct_reg <= `LDR_RESET_WORD;
		end else begin
			if (wr_lux_h) begin
				lux_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB] <= i_wdata;
			end
			if (wr_lux_l) begin
				lux_reg[`LDR_LOW_MSB:`LDR_LOW_LSB] <= i_wdata;
			end
			if (wr_cct_h) begin
				cct_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB] <= i_wdata;
			end
			if (wr_cct_l) begin
				cct_reg[`LDR_LOW_MSB:`LDR_LOW_LSB] <= i_wdata;
			end
		end
	end

	// raw words move as a set; bus writes never touch them
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			raw_x_reg <= `LDR_RESET_WORD;
			raw_y_reg <= `LDR_RESET_WORD;
			raw_z_reg <= `LDR_RESET_WORD;
		end else if (i_raw_valid) begin
			raw_x_reg <= i_raw_x;
			raw_y_reg <= i_raw_y;
			raw_z_reg <= i_raw_z;
		end
	end

	// read select, high byte at the lower address
	wire [7:0] rd_raw = ({8{hit_raw_x_h}} & raw_x_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_raw_x_l}} & raw_x_reg[`LDR_LOW_MSB:`LDR_LOW_LSB]) |
	                    ({8{hit_raw_y_h}} & raw_y_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_raw_y_l}} & raw_y_reg[`LDR_LOW_MSB:`LDR_LOW_LSB]) |
	                    ({8{hit_raw_z_h}} & raw_z_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_raw_z_l}} & raw_z_reg[`LDR_LOW_MSB:`LDR_LOW_LSB]);

	wire [7:0] rd_res = ({8{hit_res1_h}} & ch1_q[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_res1_l}} & ch1_q[`LDR_LOW_MSB:`LDR_LOW_LSB]) |
	                    ({8{hit_res2_h}} & ch2_q[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_res2_l}} & ch2_q[`LDR_LOW_MSB:`LDR_LOW_LSB]) |
	                    ({8{hit_res3_h}} & ch3_q[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_res3_l}} & ch3_q[`LDR_LOW_MSB:`LDR_LOW_LSB]);

	wire [7:0] rd_tgt = ({8{hit_lux_h}} & lux_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_lux_l}} & lux_reg[`LDR_LOW_MSB:`LDR_LOW_LSB]) |
	                    ({8{hit_cct_h}} & cct_reg[`LDR_HIGH_MSB:`LDR_HIGH_LSB]) |
	                    ({8{hit_cct_l}} & cct_reg[`LDR_LOW_MSB:`LDR_LOW_LSB]);

	// unused setup and handshake bits read as zero
	wire [7:0] rd_ctl = ({8{hit_setup}} & {mode_reg, 4'h0}) |
	                    ({8{hit_hand}} & {7'h00, start_reg});

	wire [7:0] rd_mux = rd_raw | rd_res | rd_tgt | rd_ctl;

	assign rdata_next = i_rd ? rd_mux : `LDR_UNMAPPED_READ;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= `LDR_RESET_BYTE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata        = rdata_reg;
	assign o_conv_start   = start_reg;
	assign o_channel_mode = mode_reg;
	assign o_lux_target   = lux_reg;
	assign o_cct_target   = cct_reg;

	default clocking cb @(posedge i_ref_clk);
	endclocking

	default disable iff (!i_nrst);

	sequence s_load_step;
		state_reg == ldr_st_load;
	endsequence

	sequence s_clear_step;
		(state_reg == ldr_st_clear) && !wr_hand;
	endsequence

	sequence s_start_taken;
		!start_reg ##1 start_reg;
	endsequence

	chk_pairs_then_clear: assert property (
		s_load_step ##1 s_clear_step |=> !start_reg && ch1_q == cap1_reg
		                                && ch2_q == $past(ch2_load_val, 2)
		                                && ch3_q == $past(ch3_load_val, 2))
		else $error("start cleared without a full result set");

	chk_start_clears: assert property (
		$fell(start_reg) |-> $past(state_reg) == ldr_st_clear || $past(wr_hand))
		else $error("start bit dropped with no cause");

	chk_start_holds: assert property (
		s_start_taken ##0 (state_reg == ldr_st_idle) |=> state_reg == ldr_st_wait)
		else $error("start request not taken up");

	chk_ch1_loaded: assert property (
		s_load_step |=> ch1_q == $past(cap1_reg))
		else $error("channel 1 result not loaded");

	chk_ch2_mode_zero: assert property (
		s_load_step ##0 (mode_reg == `LDR_MODE_DAY) |=> ch2_q == `LDR_RESET_WORD)
		else $error("channel 2 not zero in mode 0");

	chk_ch3_mode_zero: assert property (
		s_load_step ##0 (mode_reg == `LDR_MODE_DAY) |=> ch3_q == `LDR_RESET_WORD)
		else $error("channel 3 not zero in mode 0");

	chk_ch2_tuned_word: assert property (
		s_load_step ##0 mode_tuning |=> ch2_q == $past(cap2_reg) && ch3_q == $past(cap3_reg))
		else $error("tuned channel words not loaded");

	chk_lux_high_write: assert property (
		wr_lux_h |=> o_lux_target[`LDR_HIGH_MSB:`LDR_HIGH_LSB] == $past(i_wdata))
		else $error("lux high byte not stored");

	chk_cct_read_back: assert property (
		(i_rd && hit_cct_l) |=> o_rdata == cct_reg[`LDR_LOW_MSB:`LDR_LOW_LSB])
		else $error("colour temperature low byte misread");

	chk_raw_read_only: assert property (
		(i_wr && hit_raw_x_h && !i_raw_valid) |=> $stable(raw_x_reg))
		else $error("raw value changed by a bus write");

	chk_mode_field: assert property (
		wr_setup |=> o_channel_mode == $past(i_wdata[`LDR_MODE_MSB:`LDR_MODE_LSB]))
		else $error("channel mode field not stored");

	chk_read_one_cycle: assert property (
		!i_rd |=> o_rdata == `LDR_UNMAPPED_READ)
		else $error("read data outside the answer cycle");

	sequence s_wait_step;
		state_reg == ldr_st_wait;
	endsequence

	// a stray engine pulse must not reach the next result set
	chk_valid_refused: assert property (
		(state_reg != ldr_st_wait || !start_reg) |=>
			$stable(cap1_reg) && $stable(cap2_reg) && $stable(cap3_reg))
		else $error("result accepted outside a live request");

	chk_abort_wait: assert property (
		s_wait_step ##0 !start_reg |=> state_reg == ldr_st_idle)
		else $error("withdrawn request left pending");

	chk_pairs_held: assert property (
		!load_pairs |=> $stable(ch1_q) && $stable(ch2_q) && $stable(ch3_q))
		else $error("result pair changed outside the load cycle");

	chk_load_to_clear: assert property (
		s_load_step |=> state_reg == ldr_st_clear)
		else $error("load not followed by clear");

endmodule // ldr_result_regs

`default_nettype wire

/* test/ldr_host_model.sv */
// host side bus model: byte writes and reads on the register port
`timescale 1ns/1ns
`default_nettype none

module ldr_host_model (
	input  wire logic       i_ref_clk,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd,
	input  wire logic [7:0] i_rdata
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// released lines flip so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// data stand only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule // ldr_host_model

`default_nettype wire

/* test/ldr_result_regs_test.sv */
// self-checking bench for the lighting director register bank
`timescale 1ns/1ns
`default_nettype none
`include "ldr_regs.svh"

module ldr_result_regs_test;
	import ldr_pkg::*;
	logic       i_ref_clk = 1'b0;
	logic       i_nrst = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic       wr, rd, raw_valid, res_valid, start;
	ldr_word_t  raw_x, raw_y, raw_z, ch1, ch2, ch3, lux, colour_temperature;
	ldr_mode_t  mode;
	int         n_fail = 0;
	int         comparisons = 0;
	logic       timed_out = 1'b0;

	always #25 i_ref_clk = ~i_ref_clk;

	ldr_host_model host (.i_ref_clk(i_ref_clk), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd), .i_rdata(rdata));

	ldr_result_regs DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_raw_valid(raw_valid), .i_raw_x(raw_x), .i_raw_y(raw_y), .i_raw_z(raw_z),
		.i_result_valid(res_valid), .i_ch1_value(ch1), .i_ch2_value(ch2),
		.i_ch3_value(ch3), .o_conv_start(start), .o_channel_mode(mode),
		.o_lux_target(lux), .o_cct_target(colour_temperature));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// high byte sits at the lower address
	task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
		logic [7:0] h, l;
		host.rd(a, h);
		host.rd(a + 8'h01, l);
		chk({h, l}, exp);
	endtask

	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one engine pulse, then the words flip so a late capture shows
	task automatic pulse(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		@(posedge i_ref_clk);
		res_valid <= 1'b1;
		ch1 <= a;
		ch2 <= b;
		ch3 <= c;
		@(posedge i_ref_clk);
		res_valid <= 1'b0;
		ch1 <= ~a;
		ch2 <= ~b;
		ch3 <= ~c;
	endtask

	task automatic t_reset;
		chk(start, 1'b0);
		rd16(`LDR_ADDR_RES1_HIGH, 16'h0000);
		rd16(`LDR_ADDR_RES2_HIGH, 16'h0000);
		rd16(`LDR_ADDR_RES3_HIGH, 16'h0000);
		rd16(`LDR_ADDR_LUX_HIGH, 16'h0000);
		rd16(`LDR_ADDR_CCT_HIGH, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_targets;
		host.wr(`LDR_ADDR_LUX_HIGH, 8'h03);
		host.wr(`LDR_ADDR_LUX_LOW, 8'he8);
		host.wr(`LDR_ADDR_CCT_HIGH, 8'h0b);
		host.wr(`LDR_ADDR_CCT_LOW, 8'hb8);
		#1;
		chk(lux, 16'h03e8);
		chk(colour_temperature, 16'h0bb8);
		rd16(`LDR_ADDR_LUX_HIGH, 16'h03e8);
		rd16(`LDR_ADDR_CCT_HIGH, 16'h0bb8);
		$display("test targets done");
	endtask

	// reserved modes are handled like mode 0 on channels 2 and 3
	task automatic t_conv(input logic [3:0] m);
		logic [15:0] v1, v2, v3;
		int i;
		v1 = 16'h1a4f + {12'h000, m};
		v2 = 16'hffff - {12'h000, m};
		v3 = 16'h8000 + {12'h000, m};
		host.wr(`LDR_ADDR_SETUP, {m, 4'hf});
		#1;
		chk(mode, m);
		rd16(`LDR_ADDR_SETUP - 8'h01, {8'h00, m, 4'h0});
		host.wr(`LDR_ADDR_HANDSHAKE, 8'h01);
		@(posedge i_ref_clk);
		#1;
		chk(start, 1'b1);
		pulse(v1, v2, v3);
		for (i = 0; i < 20 && start !== 1'b0; i++) begin
			@(posedge i_ref_clk);
			#1;
		end
		if (i == 20) begin
			n_fail++;
			timed_out = 1'b1;
			return;
		end
		rd16(`LDR_ADDR_SETUP, {m, 4'h0, 8'h00});
		rd16(`LDR_ADDR_RES1_HIGH, v1);
		rd16(`LDR_ADDR_RES2_HIGH, (m == 4'h1 || m == 4'h2) ? v2 : 16'h0000);
		rd16(`LDR_ADDR_RES3_HIGH, (m == 4'h1 || m == 4'h2) ? v3 : 16'h0000);
		$display("test conversion mode %0d done", m);
	endtask

	// stray pulses dropped; a write in the clearing cycle wins; a withdrawn request
	task automatic t_refuse;
		pulse(16'h2222, 16'h3333, 16'h4444);
		rd16(`LDR_ADDR_RES1_HIGH, 16'h1a52);
		host.wr(`LDR_ADDR_HANDSHAKE, 8'h01);
		pulse(16'h5555, 16'h6666, 16'h7777);
		host.wr(`LDR_ADDR_HANDSHAKE, 8'h01);
		#1;
		chk(start, 1'b1);
		rd16(`LDR_ADDR_RES1_HIGH, 16'h5555);
		rd16(`LDR_ADDR_RES2_HIGH, 16'h0000);
		host.wr(`LDR_ADDR_HANDSHAKE, 8'h00);
		pulse(16'h8888, 16'h9999, 16'haaaa);
		rd16(`LDR_ADDR_SETUP, 16'h3000);
		rd16(`LDR_ADDR_RES1_HIGH, 16'h5555);
		$display("test refused pulses done");
	endtask

	task automatic t_raw;
		logic [7:0] d;
		@(posedge i_ref_clk);
		raw_valid <= 1'b1;
		raw_x <= 16'h1234;
		raw_y <= 16'hffff;
		raw_z <= 16'h00a5;
		@(posedge i_ref_clk);
		raw_valid <= 1'b0;
		raw_x <= 16'h0000;
		raw_y <= 16'h0000;
		raw_z <= 16'h0000;
		host.wr(`LDR_ADDR_RAW_X_HIGH, 8'h77);
		rd16(`LDR_ADDR_RAW_X_HIGH, 16'h1234);
		rd16(`LDR_ADDR_RAW_Y_HIGH, 16'hffff);
		rd16(`LDR_ADDR_RAW_Z_HIGH, 16'h00a5);
		host.rd(8'h40, d);
		chk({8'h00, d}, 16'h0000);
		$display("test raw done");
	endtask

	initial begin
		res_valid = 1'b0;
		raw_valid = 1'b0;
		{raw_x, raw_y, raw_z, ch1, ch2, ch3} = '0;
		repeat (6) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		t_reset();
		t_targets();
		for (int m = 0; m < 4; m++) begin
			if (!timed_out) begin
				t_conv(m[3:0]);
			end
		end
		if (!timed_out) begin
			t_refuse();
			t_raw();
		end
		conclude();
	end
endmodule // ldr_result_regs_test

`default_nettype wire
